// [tmc_pkg.sv]
// constants, types and mode decoding for the 16-bit timer control block
// assumes a 32-bit AXI4-Lite slave port and one clock, mclk at 40 MHz
// Behaviour
// - wave mode is control A bits 1:0 plus control B bits 4:3; 13 reserved.
// - mode 0 wraps at 0xFFFF, compare loads at once, overflow at MAX.
// - modes 1-3 dual slope to 0x00FF/0x01FF/0x03FF, load at TOP, overflow at BOTTOM.
// - fast modes 5-7 fixed top, 14/15 capture or compare top; load BOTTOM, flag TOP.
// - clear modes 4 and 12 use compare A or capture as top; flag at MAX.
// - modes 8/9 top capture or compare A, load and flag at BOTTOM.
// - modes 10/11 top capture or compare A, load at TOP, flag at BOTTOM.
// - noise cancel bit 7 needs four equal input samples before output changes.
// - edge select bit 6: zero falling, one rising capture edge.
// - selected edge copies counter into capture register and sets capture flag.
// - capture input is disconnected while capture register serves as TOP.
// - clock select 0 stops; 1 to 4 divide clock by 1, 8, 64, 256.
// - clock select 5 divides by 1024; 6 and 7 count external falling/rising edges.
package tmc_pkg;
  localparam int ADDR_W = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A  = 8'h90;
  localparam logic [7:0] IDX_CTRL_B  = 8'h91;
  localparam logic [7:0] IDX_COUNT   = 8'h94;
  localparam logic [7:0] IDX_CAPTURE = 8'h96;
  localparam logic [7:0] IDX_CMP_A   = 8'h98;
  localparam logic [7:0] IDX_STATUS  = 8'hA0;
  localparam logic [7:0] IDX_CLEAR   = 8'hA1;
  localparam logic [7:0] IDX_ENABLE  = 8'hA2;
  // field positions
  localparam int CA_WAVE_LSB = 0;
  localparam int CB_WAVE_LSB = 3;
  localparam int CB_CS_LSB   = 0;
  localparam int CB_EDGE     = 6;
  localparam int CB_NOISE    = 7;
  localparam int ST_OVF      = 0;
  localparam int ST_CAP      = 1;
  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // counter limits and timing
  localparam logic [15:0] TOP_8  = 16'h00FF;
  localparam logic [15:0] TOP_9  = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] MAX_V  = 16'hFFFF;
  localparam int NOISE_SAMPLES = 4;
  localparam int PRE_W = 10;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {PT_NOW, PT_TOP, PT_BOT} tmc_point_type;
  typedef enum logic {DIR_UP, DIR_DOWN} tmc_dir_type;

  // dual slope modes
  function automatic logic isDual(input logic [3:0] m);
    isDual = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
  endfunction

  // capture register serves as top
  function automatic logic capIsTop(input logic [3:0] m);
    capIsTop = (m inside {4'h8, 4'hA, 4'hC, 4'hE});
  endfunction

  // top value of each mode; reserved 13 behaves as mode 0
  function automatic logic [15:0] modeTop(input logic [3:0] m,
                                          input logic [15:0] cmp,
                                          input logic [15:0] cap);
    unique case (m)
      4'h1, 4'h5: modeTop = TOP_8;
      4'h2, 4'h6: modeTop = TOP_9;
      4'h3, 4'h7: modeTop = TOP_10;
      4'h4, 4'h9, 4'hB, 4'hF: modeTop = cmp;
      4'h8, 4'hA, 4'hC, 4'hE: modeTop = cap;
      default: modeTop = MAX_V;
    endcase
  endfunction

  // when the compare buffer reaches the active compare value
  function automatic tmc_point_type loadPoint(input logic [3:0] m);
    unique case (m)
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: loadPoint = PT_TOP;
      4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE, 4'hF: loadPoint = PT_BOT;
      default: loadPoint = PT_NOW;
    endcase
  endfunction

  // where the overflow flag sets; PT_NOW stands for MAX here
  function automatic tmc_point_type flagPoint(input logic [3:0] m);
    unique case (m)
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: flagPoint = PT_TOP;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: flagPoint = PT_BOT;
      default: flagPoint = PT_NOW;
    endcase
  endfunction

  // byte-lane merge of a write into a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
endpackage

// [tmc_timer16.sv]
// 16-bit timer mode, clock select and input capture with AXI4-Lite registers
// assumes pins synchronous to mclk domain only after the two-flop stages below
`timescale 1ns/100ps
module tmc_timer16 (
  // clock, reset, enable
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  // pins
  input  wire logic                     capturePin,
  input  wire logic                     extCountPin,
  // axi write
  input  wire logic [tmc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // axi read
  input  wire logic [tmc_pkg::ADDR_W-1:0] araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // status
  output logic                          irq,
  output logic [15:0]                   timerCount
);
  ////////////////////////////////////////////////////////////////////////////
  logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [7:0]  awIdx_r, awIdx_nxt;
  logic [31:0] wData_r, wData_nxt, rData_r, rData_nxt;
  logic [3:0]  wStrb_r, wStrb_nxt;
  logic        bValid_r, bValid_nxt, rValid_r, rValid_nxt;
  logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic        doWrite;
  logic [7:0]  ctrlA_r, ctrlA_nxt, ctrlB_r, ctrlB_nxt;
  logic [15:0] cnt_r, cnt_nxt, capReg_r, capReg_nxt;
  logic [15:0] cmpBuf_r, cmpBuf_nxt, cmpAct_r, cmpAct_nxt;
  logic [1:0]  status_r, status_nxt, enable_r, enable_nxt;
  logic [tmc_pkg::PRE_W-1:0] pre_r, pre_nxt;
  tmc_pkg::tmc_dir_type dir_r, dir_nxt;
  logic        capS1_r, capS2_r, extS1_r, extS2_r, extS3_r;
  logic [tmc_pkg::NOISE_SAMPLES-2:0] capHist_r, capHist_nxt;
  logic        capFilt_r, capFilt_nxt, capPrev_r, capPrev_nxt;
  logic [3:0]  waveMode;
  logic [2:0]  clkSel;
  logic [15:0] top;
  logic        tick, atTop, atBot, atMax, capIn, capEdge, allSame;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes; readies drop with ce so nothing is taken while frozen
  assign awready = ce && !awHeld_r && !bValid_r;
  assign wready  = ce && !wHeld_r && !bValid_r;
  assign arready = ce && !rValid_r;
  assign doWrite = ce && awHeld_r && wHeld_r && !bValid_r;
  assign bvalid  = bValid_r;
  assign bresp   = bResp_r;
  assign rvalid  = rValid_r;
  assign rresp   = rResp_r;
  assign rdata   = rData_r;

  // bus next state: address and data latch independently, answer follows both
  always_comb begin
    awHeld_nxt = awHeld_r;
    awIdx_nxt  = awIdx_r;
    wHeld_nxt  = wHeld_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    if (awvalid && awready) begin
      awHeld_nxt = 1'b1;
      awIdx_nxt  = awaddr[9:2];
    end
    if (wvalid && wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata;
      wStrb_nxt = wstrb;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = awIdx_r inside {tmc_pkg::IDX_CTRL_A, tmc_pkg::IDX_CTRL_B,
                     tmc_pkg::IDX_CAPTURE, tmc_pkg::IDX_CMP_A, tmc_pkg::IDX_CLEAR,
                     tmc_pkg::IDX_ENABLE} ? tmc_pkg::RESP_OK : tmc_pkg::RESP_ERR;
    end else if (bValid_r && bready) begin
      bValid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = tmc_pkg::RESP_OK;
      unique case (araddr[9:2])
        tmc_pkg::IDX_CTRL_A:  rData_nxt = {24'h000000, ctrlA_r};
        tmc_pkg::IDX_CTRL_B:  rData_nxt = {24'h000000, ctrlB_r};
        tmc_pkg::IDX_COUNT:   rData_nxt = {16'h0000, cnt_r};
        tmc_pkg::IDX_CAPTURE: rData_nxt = {16'h0000, capReg_r};
        tmc_pkg::IDX_CMP_A:   rData_nxt = {16'h0000, cmpBuf_r};
        tmc_pkg::IDX_STATUS:  rData_nxt = {30'h00000000, status_r};
        tmc_pkg::IDX_CLEAR:   rData_nxt = 32'h00000000; // write only
        tmc_pkg::IDX_ENABLE:  rData_nxt = {30'h00000000, enable_r};
        default: begin
          rData_nxt = 32'h00000000;
          rResp_nxt = tmc_pkg::RESP_ERR;
        end
      endcase
    end else if (rValid_r && rready) begin
      rValid_nxt = 1'b0;
    end
  end

  // bus registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      awIdx_r  <= 8'h00;
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h00000000;
      wStrb_r  <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r  <= tmc_pkg::RESP_OK;
      rValid_r <= 1'b0;
      rData_r  <= 32'h00000000;
      rResp_r  <= tmc_pkg::RESP_OK;
    end else if (ce) begin
      awHeld_r <= awHeld_nxt;
      awIdx_r  <= awIdx_nxt;
      wHeld_r  <= wHeld_nxt;
      wData_r  <= wData_nxt;
      wStrb_r  <= wStrb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r  <= bResp_nxt;
      rValid_r <= rValid_nxt;
      rData_r  <= rData_nxt;
      rResp_r  <= rResp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and prescaled tick
  assign waveMode = {ctrlB_r[tmc_pkg::CB_WAVE_LSB +: 2],
                     ctrlA_r[tmc_pkg::CA_WAVE_LSB +: 2]};
  assign clkSel   = ctrlB_r[tmc_pkg::CB_CS_LSB +: 3];
  assign top      = tmc_pkg::modeTop(waveMode, cmpAct_r, capReg_r);
  always_comb begin
    unique case (clkSel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = &pre_r[2:0];
      3'h3: tick = &pre_r[5:0];
      3'h4: tick = &pre_r[7:0];
      3'h5: tick = &pre_r[9:0];
      3'h6: tick = extS3_r && !extS2_r;
      3'h7: tick = extS2_r && !extS3_r;
    endcase
  end
  assign atTop = tick && (cnt_r == top);
  assign atBot = tick && (cnt_r == 16'h0000);
  assign atMax = tick && (cnt_r == tmc_pkg::MAX_V);

  // capture path: filter after the synchroniser, edge chosen by control B
  assign capIn   = ctrlB_r[tmc_pkg::CB_NOISE] ? capFilt_r : capS2_r;
  assign allSame = (capHist_r == {(tmc_pkg::NOISE_SAMPLES-1){capS2_r}});
  assign capEdge = !tmc_pkg::capIsTop(waveMode) &&
                   (ctrlB_r[tmc_pkg::CB_EDGE] ? (capIn && !capPrev_r)
                                              : (!capIn && capPrev_r));
  assign irq        = |(status_r & enable_r);
  assign timerCount = cnt_r;

  // core next state
  always_comb begin
    ctrlA_nxt   = ctrlA_r;
    ctrlB_nxt   = ctrlB_r;
    cnt_nxt     = cnt_r;
    capReg_nxt  = capReg_r;
    cmpBuf_nxt  = cmpBuf_r;
    cmpAct_nxt  = cmpAct_r;
    status_nxt  = status_r;
    enable_nxt  = enable_r;
    dir_nxt     = dir_r;
    pre_nxt     = pre_r + 1'b1;
    capHist_nxt = {capHist_r[tmc_pkg::NOISE_SAMPLES-3:0], capS2_r};
    capFilt_nxt = allSame ? capS2_r : capFilt_r;
    capPrev_nxt = capIn;
    // software writes; hardware events below take precedence
    if (doWrite) begin
      unique case (awIdx_r)
        tmc_pkg::IDX_CTRL_A:  if (wStrb_r[0]) ctrlA_nxt = wData_r[7:0];
        tmc_pkg::IDX_CTRL_B:  if (wStrb_r[0]) ctrlB_nxt = wData_r[7:0] & 8'hDF;
        tmc_pkg::IDX_CAPTURE: capReg_nxt = tmc_pkg::merge16(capReg_r, wData_r, wStrb_r);
        tmc_pkg::IDX_CMP_A:   cmpBuf_nxt = tmc_pkg::merge16(cmpBuf_r, wData_r, wStrb_r);
        tmc_pkg::IDX_CLEAR:   if (wStrb_r[0]) status_nxt = status_r & ~wData_r[1:0];
        tmc_pkg::IDX_ENABLE:  if (wStrb_r[0]) enable_nxt = wData_r[1:0];
        default: ;
      endcase
    end
    // counting sequence
    if (tick) begin
      if (tmc_pkg::isDual(waveMode)) begin
        if (dir_r == tmc_pkg::DIR_UP) begin
          if (cnt_r >= top) begin
            dir_nxt = tmc_pkg::DIR_DOWN;
            cnt_nxt = cnt_r - 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end else if (cnt_r == 16'h0000) begin
          dir_nxt = tmc_pkg::DIR_UP;
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end else begin
        dir_nxt = tmc_pkg::DIR_UP;
        cnt_nxt = (cnt_r >= top) ? 16'h0000 : cnt_r + 1'b1;
      end
    end
    // compare buffer to active value
    unique case (tmc_pkg::loadPoint(waveMode))
      tmc_pkg::PT_NOW: cmpAct_nxt = cmpBuf_nxt;
      tmc_pkg::PT_TOP: if (atTop) cmpAct_nxt = cmpBuf_r;
      tmc_pkg::PT_BOT: if (atBot) cmpAct_nxt = cmpBuf_r;
      default: ;
    endcase
    // overflow flag: set beats a clear in the same cycle
    unique case (tmc_pkg::flagPoint(waveMode))
      tmc_pkg::PT_NOW: if (atMax) status_nxt[tmc_pkg::ST_OVF] = 1'b1;
      tmc_pkg::PT_TOP: if (atTop) status_nxt[tmc_pkg::ST_OVF] = 1'b1;
      tmc_pkg::PT_BOT: if (atBot) status_nxt[tmc_pkg::ST_OVF] = 1'b1;
      default: ;
    endcase
    // capture event; with capture as top the flag marks reaching top instead
    if (capEdge) begin
      capReg_nxt = cnt_r;
      status_nxt[tmc_pkg::ST_CAP] = 1'b1;
    end
    if (tmc_pkg::capIsTop(waveMode) && atTop) begin
      status_nxt[tmc_pkg::ST_CAP] = 1'b1;
    end
  end

  // core registers; first synchroniser flops feed only their second flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrlA_r   <= tmc_pkg::CTRL_RST;
      ctrlB_r   <= tmc_pkg::CTRL_RST;
      cnt_r     <= tmc_pkg::WORD_RST;
      capReg_r  <= tmc_pkg::WORD_RST;
      cmpBuf_r  <= tmc_pkg::WORD_RST;
      cmpAct_r  <= tmc_pkg::WORD_RST;
      status_r  <= 2'h0;
      enable_r  <= 2'h0;
      dir_r     <= tmc_pkg::DIR_UP;
      pre_r     <= '0;
      capS1_r   <= 1'b0;
      capS2_r   <= 1'b0;
      extS1_r   <= 1'b0;
      extS2_r   <= 1'b0;
      extS3_r   <= 1'b0;
      capHist_r <= '0;
      capFilt_r <= 1'b0;
      capPrev_r <= 1'b0;
    end else if (ce) begin
      ctrlA_r   <= ctrlA_nxt;
      ctrlB_r   <= ctrlB_nxt;
      cnt_r     <= cnt_nxt;
      capReg_r  <= capReg_nxt;
      cmpBuf_r  <= cmpBuf_nxt;
      cmpAct_r  <= cmpAct_nxt;
      status_r  <= status_nxt;
      enable_r  <= enable_nxt;
      dir_r     <= dir_nxt;
      pre_r     <= pre_nxt;
      capS1_r   <= capturePin;
      capS2_r   <= capS1_r;
      extS1_r   <= extCountPin;
      extS2_r   <= extS1_r;
      extS3_r   <= extS2_r;
      capHist_r <= capHist_nxt;
      capFilt_r <= capFilt_nxt;
      capPrev_r <= capPrev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_mode_low;
    @(posedge mclk) disable iff (!rstn)
    doWrite && awIdx_r == tmc_pkg::IDX_CTRL_A && wStrb_r[0]
    |=> waveMode[1:0] == $past(wData_r[1:0]);
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("wave mode low bits wrong");
  property p_wrap;
    @(posedge mclk) disable iff (!rstn)
    ce && waveMode == 4'h0 && atMax |=> cnt_r == 16'h0000 && status_r[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("normal mode wrap wrong");
  property p_dual8;
    @(posedge mclk) disable iff (!rstn)
    ce && waveMode == 4'h1 && dir_r == tmc_pkg::DIR_UP && tick && cnt_r == 16'h00FF
    |=> cnt_r == 16'h00FE;
  endproperty
  a_dual8: assert property (p_dual8) else $error("dual slope turn wrong");
  property p_fast_flag;
    @(posedge mclk) disable iff (!rstn)
    ce && waveMode == 4'h5 && tick && cnt_r == 16'h00FF |=> cnt_r == 16'h0000 && status_r[0];
  endproperty
  a_fast_flag: assert property (p_fast_flag) else $error("fast flag missing");
  property p_clear_load;
    @(posedge mclk) disable iff (!rstn)
    ce && waveMode == 4'h4 |=> cmpAct_r == cmpBuf_r;
  endproperty
  a_clear_load: assert property (p_clear_load) else $error("compare not immediate");
  property p_noise;
    @(posedge mclk) disable iff (!rstn)
    ce && capFilt_r != capFilt_nxt |-> allSame && capHist_r[0] == capFilt_nxt;
  endproperty
  a_noise: assert property (p_noise) else $error("filter changed early");
  property p_capture;
    @(posedge mclk) disable iff (!rstn)
    ce && capEdge |=> capReg_r == $past(cnt_r) && status_r[1];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");
  property p_disconnect;
    @(posedge mclk) disable iff (!rstn)
    tmc_pkg::capIsTop(waveMode) && !doWrite |=> $stable(capReg_r);
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("capture while top");
  property p_stopped;
    @(posedge mclk) disable iff (!rstn)
    clkSel == 3'h0 ##1 clkSel == 3'h0 |-> $stable(cnt_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");
endmodule

// [tmc_pin_model.sv]
// far-side model: capture input and external count clock
// assumes the bench calls its tasks from the mclk domain
`timescale 1ns/100ps
module tmc_pin_model (
  // clock
  input  wire logic mclk,
  // pins
  output logic      capturePin,
  output logic      extCountPin
);
  ////////////////////////////////////////
  // both pins idle low until driven
  initial begin
    capturePin  = 1'b0;
    extCountPin = 1'b0;
  end

  // hold a capture level n cycles; short holds make glitches
  task automatic capLevel(input logic v, input int n);
    @(posedge mclk);
    capturePin <= v;
    repeat (n) @(posedge mclk);
  endtask

  // n full count periods, slow enough for the pin synchroniser
  task automatic extPulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      extCountPin <= 1'b1;
      repeat (3) @(posedge mclk);
      extCountPin <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule

// [tmc_timer16_tb_top.sv]
// self-checking bench: registers, clock select, modes, capture, irq
// assumes tmc_pkg, tmc_pin_model and tmc_timer16 compiled before it
`timescale 1ns/100ps
module tmc_timer16_tb_top;
  ////////////////////////////////////////
  // design signals, inputs valued at time zero
  logic                         mclk    = 1'b0;
  logic                         rstn    = 1'b0;
  logic                         ce      = 1'b1;
  logic [tmc_pkg::ADDR_W-1:0]   awaddr  = '0;
  logic [tmc_pkg::ADDR_W-1:0]   araddr  = '0;
  logic [31:0]                  wdata   = 32'h0;
  logic [3:0]                   wstrb   = 4'h0;
  logic                         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                         arvalid = 1'b0, rready = 1'b0;
  logic                         capturePin, extCountPin, awready, wready, bvalid;
  logic                         arready, rvalid, irq;
  logic [1:0]                   bresp, rresp, rs;
  logic [31:0]                  rdata, rv;
  logic [15:0]                  timerCount, cmpV, capV, cv, c0, mx;
  logic [31:0]                  lfsr    = 32'h00013314;
  logic [3:0]                   m;
  logic [3:0]                   modes [15] = '{4'h4, 4'h9, 4'hB, 4'hF, 4'h8, 4'hA, 4'hC,
                                  4'hE, 4'h1, 4'h5, 4'h2, 4'h6, 4'h3, 4'h7, 4'h0};
  int                           divs [8] = '{1, 1, 8, 64, 256, 1024, 2, 2};
  int                           n_fail = 0, comparisons = 0, enM = 0, top;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  tmc_pin_model pins (.mclk, .capturePin, .extCountPin);
  tmc_timer16 dut (.mclk, .rstn, .ce, .capturePin, .extCountPin, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .timerCount);

  ////////////////////////////////////////
  // comparison, verdict and hang cut-off
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    stop_test();
  endtask

  // bus master: ready sampled at negedge, so no edge race
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge mclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge mclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      rs = bresp;
      @(posedge mclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [7:0] idx);
    logic ah, dh;
    @(posedge mclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge mclk);
      ah = arvalid & arready;
      dh = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge mclk);
      if (ah) arvalid <= 1'b0;
      if (dh) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rv, exp);
  endtask

  // counter stopped while the mode bits change
  task automatic setMode(input logic [3:0] md, input logic [2:0] cs, input logic [1:0] ne);
    wr(tmc_pkg::IDX_CTRL_B, {24'h0, ne, 1'b0, md[3:2], 3'h0});
    wr(tmc_pkg::IDX_CTRL_A, {30'h0, md[1:0]});
    wr(tmc_pkg::IDX_CTRL_B, {24'h0, ne, 1'b0, md[3:2], cs});
  endtask
  task automatic watchMax(input int n, output logic [15:0] mxo);
    mxo = 16'h0000;
    repeat (n) begin
      @(negedge mclk);
      if (timerCount > mxo) mxo = timerCount;
    end
  endtask

  // one capture-pin step, then capture register and flags checked and cleared
  task automatic capStep(input logic v, input int n, input logic [15:0] ec, input logic [1:0] es);
    pins.capLevel(v, n);
    rdChk(tmc_pkg::IDX_CAPTURE, {16'h0, ec});
    rdChk(tmc_pkg::IDX_STATUS, {30'h0, es});
    chk({31'h0, irq}, {31'h0, |(es & enM[1:0])});
    wr(tmc_pkg::IDX_CLEAR, 32'h3);
    wr(tmc_pkg::IDX_CAPTURE, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  // reference top value of each mode
  function automatic logic [15:0] expTop(input logic [3:0] md);
    case (md)
      4'h1, 4'h5: expTop = 16'h00FF;
      4'h2, 4'h6: expTop = 16'h01FF;
      4'h3, 4'h7: expTop = 16'h03FF;
      4'h4, 4'h9, 4'hB, 4'hF: expTop = cmpV;
      4'h8, 4'hA, 4'hC, 4'hE: expTop = capV;
      default: expTop = 16'hFFFF;
    endcase
  endfunction

  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rdChk(tmc_pkg::IDX_CTRL_A, 32'h0);
    rdChk(tmc_pkg::IDX_CTRL_B, 32'h0);
    wr(tmc_pkg::IDX_CTRL_B, 32'hFF);
    rdChk(tmc_pkg::IDX_CTRL_B, 32'hDF);
    wr(tmc_pkg::IDX_COUNT, 32'h5);
    chk({30'h0, rs}, {30'h0, tmc_pkg::RESP_ERR});
    rdChk(8'h50, 32'h0);
    chk({30'h0, rs}, {30'h0, tmc_pkg::RESP_ERR});
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    cmpV = 16'h0080 + (lfsr[15:0] & 16'h003F);
    capV = 16'h00C0 + (lfsr[31:16] & 16'h002F);
    wr(tmc_pkg::IDX_CMP_A, {16'h0, cmpV});
    rdChk(tmc_pkg::IDX_CMP_A, {16'h0, cmpV});
    wr(tmc_pkg::IDX_CAPTURE, {16'h0, capV});
    rdChk(tmc_pkg::IDX_CAPTURE, {16'h0, capV});
    $display("test registers done");
    // every clock select: prescaler divisors and both external edges
    for (int i = 0; i < 8; i++) begin
      setMode(4'h0, 3'(i), 2'b00);
      @(negedge mclk);
      c0 = timerCount;
      if (i > 5) pins.extPulses(4);
      repeat (4 * divs[i]) @(negedge mclk);
      chk({16'h0, timerCount - c0}, (i == 0) ? 32'h0 : 32'h4);
    end
    $display("test clock select done");
    // every mode: top reached and never passed, overflow flag point
    for (int i = 0; i < 15; i++) begin
      m = modes[i];
      setMode(m, 3'h1, 2'b00);
      wr(tmc_pkg::IDX_CLEAR, 32'h3);
      top = int'(expTop(m));
      watchMax((m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB}) ?
               2 * top + 60 : top + 60, mx);
      chk({16'h0, mx}, {16'h0, expTop(m)});
      rd(tmc_pkg::IDX_STATUS);
      chk(rv & 32'h1, (m == 4'h4 || m == 4'hC) ? 32'h0 : 32'h1);
    end
    $display("test modes done");
    // clock enable low must freeze the running counter
    ce <= 1'b0;
    @(negedge mclk);
    c0 = timerCount;
    repeat (8) @(negedge mclk);
    chk({16'h0, timerCount}, {16'h0, c0});
    @(posedge mclk);
    ce <= 1'b1;
    $display("test clock enable done");
    // capture edges, filter, disconnect and interrupt masking
    setMode(4'h0, 3'h0, 2'b01);
    wr(tmc_pkg::IDX_ENABLE, 32'h2);
    enM = 2;
    wr(tmc_pkg::IDX_CAPTURE, 32'h0);
    // flags left over from the mode sweep would spoil the first status read
    wr(tmc_pkg::IDX_CLEAR, 32'h3);
    cv = timerCount;
    capStep(1'b1, 8, cv, 2'h2);
    capStep(1'b0, 8, 16'h0, 2'h0);
    setMode(4'h0, 3'h0, 2'b00);
    capStep(1'b1, 8, 16'h0, 2'h0);
    capStep(1'b0, 8, cv, 2'h2);
    setMode(4'h0, 3'h0, 2'b11);
    // three high samples only: the filter wants four
    pins.capLevel(1'b1, 2);
    capStep(1'b0, 8, 16'h0, 2'h0);
    capStep(1'b1, 8, cv, 2'h2);
    setMode(4'h0, 3'h0, 2'b01);
    capStep(1'b0, 8, 16'h0, 2'h0);
    pins.capLevel(1'b1, 3);
    capStep(1'b0, 8, cv, 2'h2);
    setMode(4'hC, 3'h0, 2'b01);
    capStep(1'b1, 8, 16'h0, 2'h0);
    capStep(1'b0, 8, 16'h0, 2'h0);
    setMode(4'h0, 3'h0, 2'b01);
    wr(tmc_pkg::IDX_ENABLE, 32'h1);
    enM = 1;
    capStep(1'b1, 8, cv, 2'h2);
    $display("test capture done");
    stop_test();
  end
endmodule
